// ---- src/sample_fifo_pkg.sv ----
// constants, state codes and carrier types of the sensor sample fifo
`default_nettype none
package sample_fifo_pkg;
    localparam logic [7:0] ADDR_EXTRA_CFG = 8'hdf;
    localparam logic [7:0] ADDR_ITEM_MAP  = 8'hfc;
    localparam logic [7:0] ADDR_LEVEL     = 8'hfd;
    localparam logic [7:0] ADDR_READ_LOW  = 8'hfe;
    localparam logic [7:0] ADDR_READ_HIGH = 8'hff;
    localparam logic [7:0] RST_EXTRA_CFG  = 8'h21;
    localparam logic [7:0] RST_ITEM_MAP   = 8'h00;
    localparam logic [7:0] MAP_USED_MASK  = 8'h7f;
    localparam int         BIT_STORE_FL   = 7;
    localparam int         BIT_MAP_ADC5   = 6;
    localparam int         ITEM_FLICKER   = 7;
    localparam int         RAM_BYTES      = 256;
    localparam int         MAX_ENTRIES    = 128;
    localparam int         STAGE_DEPTH    = 8;

    typedef enum logic {SER_IDLE, SER_EMIT} ser_t;

    typedef struct packed {
        logic [7:0]       status;
        logic [5:0][15:0] adc;
        logic [7:0]       flicker;
    } sample_t;

    typedef struct packed {
        logic       load;
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage
`default_nettype wire

// ---- src/sensor_sample_fifo.sv ----
// sample fifo: byte staging queue and the 256-byte entry store
`default_nettype none
module byte_stage #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [CW-1:0]               cnt;
    } stage_t;
    stage_t s_ff;
    stage_t nxt_s;
    logic   push;
    logic   pull;

    assign in_ready  = s_ff.cnt != CW'(DEPTH);
    assign out_valid = s_ff.cnt != '0;
    assign out_data  = s_ff.mem[s_ff.rp];
    assign push      = in_valid && in_ready;
    assign pull      = out_valid && out_ready;

    always_comb begin
        nxt_s = s_ff;
        if (push) begin
            nxt_s.mem[s_ff.wp] = in_data;
            nxt_s.wp = (s_ff.wp == AW'(DEPTH - 1)) ? '0
                                                   : AW'(s_ff.wp + 1'b1);
        end
        if (pull) begin
            nxt_s.rp = (s_ff.rp == AW'(DEPTH - 1)) ? '0
                                                   : AW'(s_ff.rp + 1'b1);
        end
        nxt_s.cnt = CW'(s_ff.cnt + CW'(push) - CW'(pull));
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule

module sensor_sample_fifo (
    input  wire logic                       mclk,
    input  wire logic                       rst_b,
    input  wire logic                       sample_valid,
    input  wire sample_fifo_pkg::sample_t   sample,
    input  wire logic                       flicker_detect_on,
    input  wire logic                       overflow_clear,
    input  wire sample_fifo_pkg::reg_req_t  req,
    output logic                            sample_ready,
    output logic [7:0]                      rdata,
    output logic                            rdata_valid,
    output logic                            overflow
);
    typedef struct packed {
        sample_fifo_pkg::ser_t    ser;
        logic [2:0]               item;
        logic                     hi;
        logic [7:0]               en;
        sample_fifo_pkg::sample_t smp;
        logic [7:0]               map;
        logic                     store_fl;
        logic [7:0]               ptr;
        logic [7:0]               rdata;
        logic                     rvalid;
        logic                     ovf;
        logic                     rdy;
        logic [8:0]               commit;
        logic [8:0]               count;
        logic [7:0]               wr_ptr;
        logic [7:0]               rd_ptr;
        logic [255:0][7:0]        ram;
    } st_t;

    st_t        s_ff;
    st_t        nxt_s;
    logic [7:0] acc;
    logic [7:0] level;
    logic [7:0] en_now;
    logic [3:0] need_now;
    logic [3:0] nxt_item;
    logic [3:0] first_item;
    logic       try_acc;
    logic       fits;
    logic       pop;
    logic       st_in_valid;
    logic       st_in_ready;
    logic [7:0] st_in_data;
    logic       st_out_valid;
    logic [7:0] st_out_data;
    logic       drain_ready;
    logic       take;

    // first enabled item at or after from; 8 means none left
    function automatic logic [3:0] next_item(input logic [7:0] en,
                                             input logic [3:0] from);
        logic [3:0] r;
        r = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (en[i] && (4'(i) >= from)) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] need_bytes(input logic [7:0] en);
        logic [3:0] n;
        n = 4'(en[0]) + 4'(en[7]);
        for (int i = 1; i <= 6; i++) begin
            n = 4'(n + {2'h0, en[i], 1'b0});
        end
        return n;
    endfunction

    function automatic logic [7:0] byte_of(
        input sample_fifo_pkg::sample_t smp,
        input logic [2:0] item,
        input logic hi);
        logic [15:0] w;
        w = 16'h0000;
        if (item != 3'h0 && item != 3'h7) begin
            w = smp.adc[3'(item - 3'h1)];
        end
        case (item)
            3'h0:    byte_of = smp.status;
            3'h7:    byte_of = smp.flicker;
            default: byte_of = hi ? w[15:8] : w[7:0];
        endcase
    endfunction

    assign st_in_valid = s_ff.ser == sample_fifo_pkg::SER_EMIT;
    assign st_in_data  = byte_of(s_ff.smp, s_ff.item, s_ff.hi);

    // store write waits while a host read pops, keeping one ram port busy
    assign drain_ready = !pop;
    assign take        = st_out_valid && drain_ready;

    byte_stage #(
        .WIDTH (8),
        .DEPTH (sample_fifo_pkg::STAGE_DEPTH)
    ) u_stage (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .in_valid  (st_in_valid),
        .in_ready  (st_in_ready),
        .in_data   (st_in_data),
        .out_valid (st_out_valid),
        .out_ready (drain_ready),
        .out_data  (st_out_data)
    );

    always_comb begin
        en_now = {1'b0, s_ff.map[6:0]};
        en_now[sample_fifo_pkg::BIT_MAP_ADC5] =
            s_ff.map[sample_fifo_pkg::BIT_MAP_ADC5] && !flicker_detect_on;
        en_now[sample_fifo_pkg::ITEM_FLICKER] =
            s_ff.store_fl && flicker_detect_on;
        need_now = need_bytes(en_now);
        fits = ({1'b0, s_ff.commit} + 10'(need_now))
               <= 10'(sample_fifo_pkg::RAM_BYTES);
        try_acc = s_ff.rdy && sample_valid && (need_now != 4'h0);
        acc = req.load ? req.addr : s_ff.ptr;
        level = s_ff.count[8:1];
        pop = req.rd && (acc == sample_fifo_pkg::ADDR_READ_HIGH)
              && (level != 8'h00);
        nxt_item = next_item(s_ff.en, 4'(s_ff.item) + 4'h1);
        first_item = next_item(en_now, 4'h0);

        nxt_s = s_ff;
        nxt_s.rvalid = req.rd;
        if (req.rd || req.wr) begin
            nxt_s.ptr = (acc == sample_fifo_pkg::ADDR_READ_HIGH)
                        ? sample_fifo_pkg::ADDR_READ_LOW
                        : 8'(acc + 8'h01);
        end else if (req.load) begin
            nxt_s.ptr = req.addr;
        end
        if (req.wr && acc == sample_fifo_pkg::ADDR_ITEM_MAP) begin
            nxt_s.map = req.wdata & sample_fifo_pkg::MAP_USED_MASK;
        end
        // reserved config bits are held constant, writes cannot disturb them
        if (req.wr && acc == sample_fifo_pkg::ADDR_EXTRA_CFG) begin
            nxt_s.store_fl = req.wdata[sample_fifo_pkg::BIT_STORE_FL];
        end
        if (req.rd) begin
            unique case (acc)
                sample_fifo_pkg::ADDR_ITEM_MAP:  nxt_s.rdata = s_ff.map;
                sample_fifo_pkg::ADDR_EXTRA_CFG: nxt_s.rdata =
                    {s_ff.store_fl, sample_fifo_pkg::RST_EXTRA_CFG[6:0]};
                sample_fifo_pkg::ADDR_LEVEL:     nxt_s.rdata = level;
                sample_fifo_pkg::ADDR_READ_LOW:  nxt_s.rdata =
                    (level != 8'h00) ? s_ff.ram[s_ff.rd_ptr] : 8'h00;
                sample_fifo_pkg::ADDR_READ_HIGH: nxt_s.rdata =
                    (level != 8'h00) ? s_ff.ram[8'(s_ff.rd_ptr + 8'h01)]
                                     : 8'h00;
                default:                         nxt_s.rdata = 8'h00;
            endcase
        end
        if (pop) begin
            nxt_s.rd_ptr = 8'(s_ff.rd_ptr + 8'h02);
        end
        if (take) begin
            nxt_s.ram[s_ff.wr_ptr] = st_out_data;
            nxt_s.wr_ptr = 8'(s_ff.wr_ptr + 8'h01);
        end
        nxt_s.count = 9'(s_ff.count + 9'(take) - {7'h00, pop, 1'b0});

        unique case (s_ff.ser)
            sample_fifo_pkg::SER_IDLE: begin
                if (try_acc && fits) begin
                    nxt_s.smp = sample;
                    nxt_s.en  = en_now;
                    nxt_s.item = first_item[2:0];
                    nxt_s.hi  = 1'b0;
                    nxt_s.ser = sample_fifo_pkg::SER_EMIT;
                    nxt_s.rdy = 1'b0;
                end
            end
            sample_fifo_pkg::SER_EMIT: begin
                if (st_in_ready) begin
                    if (s_ff.item != 3'h0 && s_ff.item != 3'h7
                        && !s_ff.hi) begin
                        nxt_s.hi = 1'b1;
                    end else if (nxt_item[3]) begin
                        nxt_s.hi  = 1'b0;
                        nxt_s.ser = sample_fifo_pkg::SER_IDLE;
                        nxt_s.rdy = 1'b1;
                    end else begin
                        nxt_s.hi   = 1'b0;
                        nxt_s.item = nxt_item[2:0];
                    end
                end
            end
        endcase

        nxt_s.commit = 9'(s_ff.commit - {7'h00, pop, 1'b0});
        if (s_ff.ser == sample_fifo_pkg::SER_IDLE && try_acc && fits) begin
            nxt_s.commit = 9'(nxt_s.commit + 9'(need_now));
        end
        nxt_s.ovf = (try_acc && !fits) || (s_ff.ovf && !overflow_clear);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_ff          <= '0;
            s_ff.map      <= sample_fifo_pkg::RST_ITEM_MAP;
            s_ff.store_fl <= sample_fifo_pkg::RST_EXTRA_CFG[7];
            s_ff.rdy      <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign sample_ready = s_ff.rdy;
    assign rdata        = s_ff.rdata;
    assign rdata_valid  = s_ff.rvalid;
    assign overflow     = s_ff.ovf;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_store_bound: assert property (
        s_ff.count <= s_ff.commit
        && s_ff.commit <= 9'(sample_fifo_pkg::RAM_BYTES))
        else $error("store count out of range");
    a_ch5_gated: assert property (
        try_acc && fits && flicker_detect_on |=> !s_ff.en[6])
        else $error("channel five stored during flicker detection");
    a_flicker_gated: assert property (
        try_acc && fits && !flicker_detect_on |=> !s_ff.en[7])
        else $error("flicker byte stored with detection off");
    a_status_first: assert property (
        s_ff.rdy && try_acc && fits && en_now[0]
        |=> s_ff.item == 3'h0 && st_in_valid)
        else $error("status byte not emitted first");
    a_two_bytes: assert property (
        st_in_valid && st_in_ready && s_ff.item inside {[3'h1:3'h6]}
        && !s_ff.hi |=> s_ff.hi && s_ff.item == $past(s_ff.item))
        else $error("channel item lost its high byte");
    a_level_read: assert property (
        req.rd && acc == sample_fifo_pkg::ADDR_LEVEL
        |=> rdata_valid && rdata == $past(s_ff.count[8:1]))
        else $error("level read wrong");
    a_empty_zero: assert property (
        req.rd && acc[7:1] == 7'h7f && s_ff.count < 9'h002
        |=> rdata == 8'h00)
        else $error("empty queue read not zero");
    a_ptr_wrap: assert property (
        (req.rd || req.wr) && acc == sample_fifo_pkg::ADDR_READ_HIGH
        |=> s_ff.ptr == sample_fifo_pkg::ADDR_READ_LOW)
        else $error("pointer did not wrap");
    a_pop_step: assert property (
        pop && !take
        |=> s_ff.count == 9'($past(s_ff.count) - 9'h002)
        && s_ff.rd_ptr == 8'($past(s_ff.rd_ptr) + 8'h02))
        else $error("pop did not advance one entry");
    a_ovf_drop: assert property (
        try_acc && !fits |=> overflow && s_ff.rdy
        && s_ff.commit <= $past(s_ff.commit))
        else $error("overflowing sample not discarded");

    c_overflow: cover property (try_acc && !fits);
    c_full: cover property (
        s_ff.count == 9'(sample_fifo_pkg::RAM_BYTES));
    c_pop_write: cover property (pop && st_out_valid);
    c_block_read: cover property (pop ##1 req.rd ##1 pop);
endmodule
`default_nettype wire

// ---- verif/host_model.sv ----
// host model: register reads and writes on the sample fifo port
`default_nettype none
module host_model (
    input  wire logic                     mclk,
    output var sample_fifo_pkg::reg_req_t req,
    input  wire logic [7:0]               rdata,
    input  wire logic                     rdata_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk);
        req <= '{load: 1'b1, wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge mclk);
        req <= '0;
    endtask

    // load the pointer once, then read back to back
    task automatic rd(input logic [7:0] addr, input int n,
                      output logic [7:0] q [$], output logic ok);
        ok = 1'b1;
        q = {};
        @(posedge mclk);
        req <= '{load: 1'b1, wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            if (i == n - 1)
                req <= '0;
            else
                req <= '{load: 1'b0, wr: 1'b0, rd: 1'b1, addr: 8'h00,
                         wdata: 8'h00};
            #1;
            q.push_back(rdata);
            if (rdata_valid !== 1'b1)
                ok = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- verif/sensor_sample_fifo_bench.sv ----
// self-checking bench of the sensor sample fifo
`default_nettype none
module sensor_sample_fifo_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                      mclk;
    logic                      rst_b;
    logic                      sample_valid;
    sample_fifo_pkg::sample_t  sample;
    logic                      flicker_detect_on;
    logic                      overflow_clear;
    sample_fifo_pkg::reg_req_t req;
    logic                      sample_ready;
    logic [7:0]                rdata;
    logic                      rdata_valid;
    logic                      overflow;
    int                        n_errors;
    int                        checked;

    sensor_sample_fifo sensor_sample_fifo_i (
        .mclk              (mclk),
        .rst_b             (rst_b),
        .sample_valid      (sample_valid),
        .sample            (sample),
        .flicker_detect_on (flicker_detect_on),
        .overflow_clear    (overflow_clear),
        .req               (req),
        .sample_ready      (sample_ready),
        .rdata             (rdata),
        .rdata_valid       (rdata_valid),
        .overflow          (overflow)
    );

    host_model host_model_i (
        .mclk        (mclk),
        .req         (req),
        .rdata       (rdata),
        .rdata_valid (rdata_valid)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checked %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // lo byte a0+i, hi byte 10+i keeps every byte position distinct
    function automatic sample_fifo_pkg::sample_t mk(input logic [7:0] st);
        sample_fifo_pkg::sample_t s;
        s.status = st;
        s.flicker = st ^ 8'hff;
        for (int i = 0; i < 6; i++)
            s.adc[i] = {8'h10 + 8'(i), 8'ha0 + 8'(i)};
        return s;
    endfunction

    function automatic logic [7:0] adc_byte(input int k);
        return k[0] ? 8'h10 + 8'(k / 2) : 8'ha0 + 8'(k / 2);
    endfunction

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q [$];
        logic       ok;
        host_model_i.rd(a, 1, q, ok);
        check($sformatf("valid %h", a), {7'h00, ok}, 8'h01);
        check($sformatf("addr %h", a), q[0], e);
    endtask

    task automatic send(input sample_fifo_pkg::sample_t s);
        int w;
        @(posedge mclk);
        sample_valid <= 1'b1;
        sample <= s;
        #1;
        w = 0;
        while (sample_ready !== 1'b1 && w < 50) begin
            @(posedge mclk);
            #1;
            w++;
        end
        @(posedge mclk);
        sample_valid <= 1'b0;
        w = 0;
        do begin
            @(posedge mclk);
            #1;
            w++;
        end while (sample_ready !== 1'b1 && w < 50);
        check("ready back", {7'h00, sample_ready}, 8'h01);
        // let the staging queue drain into the store
        repeat (12) @(posedge mclk);
        #1;
    endtask

    task automatic t_regs();
        logic [7:0] ad [6] = '{8'hdf, 8'hfc, 8'hfd, 8'hfe, 8'hff, 8'h10};
        logic [7:0] ex [6] = '{8'h21, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++)
            chk_rd(ad[i], ex[i]);
        host_model_i.wr(8'hfc, 8'hff);
        chk_rd(8'hfc, 8'h7f);
        // keep the reserved pattern on every write
        host_model_i.wr(8'hdf, 8'ha1);
        chk_rd(8'hdf, 8'ha1);
    endtask

    task automatic t_order();
        logic [7:0] q [$];
        logic       ok;
        host_model_i.wr(8'hfc, 8'h7e);
        send(mk(8'h5a));
        chk_rd(8'hfd, 8'h06);
        host_model_i.rd(8'hfe, 8, q, ok);
        for (int k = 0; k < 8; k++)
            check("burst", q[k], adc_byte(k));
        chk_rd(8'hfd, 8'h02);
        chk_rd(8'hfe, adc_byte(8));
        chk_rd(8'hfd, 8'h02);
        chk_rd(8'hff, adc_byte(9));
        chk_rd(8'hfd, 8'h01);
        host_model_i.rd(8'hfe, 2, q, ok);
        check("ch5 lo", q[0], adc_byte(10));
        check("ch5 hi", q[1], adc_byte(11));
        chk_rd(8'hfe, 8'h00);
        chk_rd(8'hff, 8'h00);
    endtask

    task automatic t_flicker();
        logic [7:0] q [$];
        logic       ok;
        @(posedge mclk);
        flicker_detect_on <= 1'b1;
        host_model_i.wr(8'hfc, 8'h41);
        send(mk(8'h3c));
        chk_rd(8'hfd, 8'h01);
        host_model_i.rd(8'hfe, 2, q, ok);
        check("status", q[0], 8'h3c);
        check("flicker", q[1], 8'hc3);
        @(posedge mclk);
        flicker_detect_on <= 1'b0;
    endtask

    task automatic t_overflow();
        host_model_i.wr(8'hfc, 8'h7e);
        for (int i = 0; i < 21; i++)
            send(mk(8'(i)));
        chk_rd(8'hfd, 8'h7e);
        host_model_i.wr(8'hfc, 8'h03);
        send(mk(8'h01));
        chk_rd(8'hfd, 8'h7f);
        host_model_i.wr(8'hfc, 8'h01);
        send(mk(8'h02));
        chk_rd(8'hfd, 8'h80);
        check("overflow", {7'h00, overflow}, 8'h00);
        send(mk(8'h03));
        check("overflow", {7'h00, overflow}, 8'h01);
        chk_rd(8'hfd, 8'h80);
        @(posedge mclk);
        overflow_clear <= 1'b1;
        @(posedge mclk);
        overflow_clear <= 1'b0;
        repeat (2) @(posedge mclk);
        check("overflow", {7'h00, overflow}, 8'h00);
    endtask

    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end

    initial begin
        rst_b = 1'b0;
        sample_valid = 1'b0;
        sample = '0;
        flicker_detect_on = 1'b0;
        overflow_clear = 1'b0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs();
        t_order();
        t_flicker();
        t_overflow();
        give_verdict();
    end
endmodule
`default_nettype wire
